// [design/cdm_modulator.sv]
// cdm_modulator: data signal modulator control and output stage
// assumes: ahb-lite single-word accesses; carrier/modulator sources asynchronous
`timescale 1ns/10ps
module cdm_modulator
  import cdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sleep_mode,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] carrier_src_in,
  input wire logic [9:0] modulator_src_in,
  input wire logic modulator_pin_in,
  output logic modulated_output,
  output logic modulated_output_oe_n,
  output logic output_slew_limit,
  output logic [7:0] carrier_high_pin_release,
  output logic [7:0] carrier_low_pin_release,
  output logic [9:0] modulator_pin_release
);
  // -----------------------------------------------------------------
  // registers and synchronised inputs
  // -----------------------------------------------------------------
  logic [7:0] ctl_r, src_r, high_carrier_r, low_carrier_r;
  logic [7:0] car_s;
  logic [10:0] mod_s;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic mix_r;
  wire en = ctl_r[CDM_CTL_EN];

  // external sources pass two flops before use
  cdm_sync #(.W(8)) u_car_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(carrier_src_in),
    .q(car_s)
  );
  cdm_sync #(.W(11)) u_mod_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({modulator_src_in, modulator_pin_in}),
    .q(mod_s)
  );

  // -----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // -----------------------------------------------------------------
  wire addr_ok = hsel && hready && (htrans == CDM_HTRANS_NONSEQ);
  wire wr_take = addr_ok && hwrite;
  wire rd_take = addr_ok && !hwrite;

  function automatic logic [7:0] wmerge(
    input logic [7:0] old,
    input logic [7:0] nw,
    input logic [7:0] mask
  );
    wmerge = (old & ~mask) | (nw & mask);
  endfunction : wmerge

  // register read view
  // live output bit
  wire [7:0] ctl_view = {ctl_r[7:4], mix_r, 2'b00, ctl_r[CDM_CTL_BIT]};
  wire [7:0] rd_sel = (haddr[7:0] == CDM_OFF_CTL) ? ctl_view :
                      (haddr[7:0] == CDM_OFF_SRC) ? src_r :
                      (haddr[7:0] == CDM_OFF_HIGH_CARRIER) ? high_carrier_r :
                      (haddr[7:0] == CDM_OFF_LOW_CARRIER) ? low_carrier_r : 8'h00;

  // address phase capture and read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_take;
      if (wr_take) begin
        wr_addr_r <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata <= {24'h00_0000, rd_sel};
      end
    end
  end

  // always ready, always okay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  wire [7:0] wd = hwdata[7:0];
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_r <= CDM_CTL_RST;
      src_r <= CDM_SRC_RST;
      high_carrier_r <= CDM_CAR_RST;
      low_carrier_r <= CDM_CAR_RST;
    end else if (wr_pend_r) begin
      // firmware sets up before output enable
      if (wr_addr_r == CDM_OFF_CTL) ctl_r <= wmerge(ctl_r, wd, CDM_CTL_WMASK);
      if (wr_addr_r == CDM_OFF_SRC) src_r <= wmerge(src_r, wd, CDM_SRC_WMASK);
      if (wr_addr_r == CDM_OFF_HIGH_CARRIER) high_carrier_r <= wmerge(high_carrier_r, wd, CDM_CAR_WMASK);
      if (wr_addr_r == CDM_OFF_LOW_CARRIER) low_carrier_r <= wmerge(low_carrier_r, wd, CDM_CAR_WMASK);
    end
  end

  // -----------------------------------------------------------------
  // carrier selection
  // -----------------------------------------------------------------
  logic high_carrier, low_carrier;
  logic [7:0] rel_h, rel_l;
  cdm_src_mux u_high_carrier (
    .ctl(high_carrier_r),
    .en(en),
    .srcs(car_s),
    .carrier(high_carrier),
    .pin_release(rel_h)
  );
  cdm_src_mux u_low_carrier (
    .ctl(low_carrier_r),
    .en(en),
    .srcs(car_s),
    .carrier(low_carrier),
    .pin_release(rel_l)
  );

  // -----------------------------------------------------------------
  // modulator selection
  // -----------------------------------------------------------------
  // disabled uses programmed bit
  wire [3:0] ms = en ? src_r[3:0] : CDM_MS_BIT;
  wire ms_periph = (ms >= 4'h2) && (ms < 4'hC);
  wire [3:0] ms_idx = ms - 4'h2;
  wire mod_sig = (ms == CDM_MS_BIT) ? ctl_r[CDM_CTL_BIT] :
                 (ms == CDM_MS_PIN) ? mod_s[0] :
                 ms_periph ? mod_s[ms_idx + 4'h1] : 1'b0;
  wire [9:0] mrel = (en && src_r[CDM_SRC_DIS] && ms_periph) ? (10'h001 << ms_idx) : 10'h000;

  // -----------------------------------------------------------------
  // mixing and output stage
  // -----------------------------------------------------------------
  // carrier chosen by modulator, and-mixed
  wire active_car = mod_sig ? high_carrier : low_carrier;
  wire mix_nxt = (mod_sig & active_car) ^ ctl_r[CDM_CTL_POL];
  wire pin_nxt = ctl_r[CDM_CTL_OE] & mix_nxt;

  // sleep does not gate the path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mix_r <= 1'b0;
      modulated_output <= 1'b0;
      modulated_output_oe_n <= 1'b1;
      output_slew_limit <= 1'b1;
      carrier_high_pin_release <= 8'h00;
      carrier_low_pin_release <= 8'h00;
      modulator_pin_release <= 10'h000;
    end else begin
      mix_r <= mix_nxt;
      modulated_output <= pin_nxt;
      modulated_output_oe_n <= ~ctl_r[CDM_CTL_OE];
      output_slew_limit <= ctl_r[CDM_CTL_SLR];
      carrier_high_pin_release <= rel_h;
      carrier_low_pin_release <= rel_l;
      modulator_pin_release <= mrel;
    end
  end

  // sleep_mode is informational only: the block keeps running
  wire unused_ok = sleep_mode ^ hsize[0] ^ (|haddr[31:8]) ^ (|hwdata[31:8]);
endmodule : cdm_modulator

// [design/cdm_pkg.sv]
// cdm_pkg: register map, field positions, reset values and source codes
// assumes: 32-bit ahb-lite register bus, one clock domain
package cdm_pkg;
  // byte offsets of the registers
  localparam logic [7:0] CDM_OFF_CTL = 8'h00; // modulation_control
  localparam logic [7:0] CDM_OFF_SRC = 8'h04; // modulator_source_control
  localparam logic [7:0] CDM_OFF_HIGH_CARRIER = 8'h08; // high_carrier_control
  localparam logic [7:0] CDM_OFF_LOW_CARRIER = 8'h0C; // low_carrier_control
  // modulation_control fields
  localparam int CDM_CTL_EN = 7;
  localparam int CDM_CTL_OE = 6;
  localparam int CDM_CTL_SLR = 5;
  localparam int CDM_CTL_POL = 4;
  localparam int CDM_CTL_OUT = 3;
  localparam int CDM_CTL_BIT = 0;
  localparam logic [7:0] CDM_CTL_WMASK = 8'hF1; // bits 3..1 not writable
  localparam logic [7:0] CDM_CTL_RST = 8'h20; // slew limit on, all else off
  // source and carrier registers
  localparam int CDM_SRC_DIS = 7; // pin release bit of both kinds
  localparam int CDM_CAR_POL = 6;
  localparam int CDM_CAR_SYNC = 5;
  localparam logic [7:0] CDM_SRC_WMASK = 8'h8F;
  localparam logic [7:0] CDM_CAR_WMASK = 8'hEF;
  localparam logic [7:0] CDM_SRC_RST = 8'h00;
  localparam logic [7:0] CDM_CAR_RST = 8'h00;
  // modulator source codes
  localparam logic [3:0] CDM_MS_BIT = 4'h0;
  localparam logic [3:0] CDM_MS_PIN = 4'h1;
  localparam int CDM_MS_NUM = 10; // sources 0..9 are peripherals, code = index+2
  // carrier source codes: 0 ground, 1 pin1, 2 pin2, 3 refclk, 4..7 capture_compare_unit_one..4
  localparam logic [3:0] CDM_CS_GND = 4'h0;
  // ahb
  localparam logic [1:0] CDM_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] CDM_HSIZE_WORD = 3'b010;
endpackage : cdm_pkg

// [design/cdm_src_mux.sv]
// cdm_src_mux: one carrier selector with polarity and pin release
// assumes: sources already synchronised to clk_sys
`timescale 1ns/10ps
module cdm_src_mux
  import cdm_pkg::*;
(
  input wire logic [7:0] ctl,
  input wire logic en,
  input wire logic [7:0] srcs,
  output logic carrier,
  output logic [7:0] pin_release
);
  // selection, with the disabled module forced to ground
  wire [3:0] sel = en ? ctl[3:0] : CDM_CS_GND;
  wire raw = (sel[3] == 1'b0) && (sel[2:0] != 3'd0) ? srcs[sel[2:0]] : 1'b0;
  assign carrier = raw ^ (ctl[CDM_CAR_POL] & (sel != CDM_CS_GND));
  // pin release decode of the selected peripheral
  always_comb begin
    pin_release = 8'h00;
    if (ctl[CDM_SRC_DIS] && en && sel[3] == 1'b0) begin
      pin_release[sel[2:0]] = 1'b1;
    end
  end
endmodule : cdm_src_mux

// [design/cdm_sync.sv]
// cdm_sync: two-flop synchroniser for a bundle of pin or peer inputs
// assumes: inputs are asynchronous to clk_sys
`timescale 1ns/10ps
module cdm_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // two stages, first read only by the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : cdm_sync

// [verif/cdm_modulator_monitor.sv]
// cdm_modulator_monitor: port-level assertions for the modulator block
// assumes: bound to cdm_modulator, one clock, sync active-low reset
`timescale 1ns/10ps
module cdm_modulator_monitor
  import cdm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic modulated_output,
  input wire logic modulated_output_oe_n,
  input wire logic output_slew_limit,
  input wire logic [7:0] carrier_high_pin_release,
  input wire logic [7:0] carrier_low_pin_release,
  input wire logic [9:0] modulator_pin_release
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // -------------------------------------------
  // helper: control register accesses
  // -------------------------------------------
  logic rd_ctl_r;
  logic [2:0] wcnt_r;
  wire ctl_acc = hsel && hready && htrans == CDM_HTRANS_NONSEQ && haddr[7:0] == CDM_OFF_CTL;
  // flag a control read, count down after a control write
  always_ff @(posedge clk_sys) begin
    rd_ctl_r <= rst_n && ctl_acc && !hwrite;
    if (!rst_n) wcnt_r <= 3'h0;
    else if (ctl_acc && hwrite) wcnt_r <= 3'h5;
    else if (wcnt_r != 3'h0) wcnt_r <= wcnt_r - 3'h1;
  end
  property p_pin_low;
    modulated_output_oe_n |-> !modulated_output;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven while disabled");
  property p_rst_vals;
    disable iff (1'b0) !rst_n |=> output_slew_limit && modulated_output_oe_n
      && !modulated_output && modulator_pin_release == 10'h000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_ch_rel;
    $onehot0(carrier_high_pin_release);
  endproperty
  a_ch_rel: assert property (p_ch_rel) else $error("high release not one-hot");
  property p_cl_rel;
    $onehot0(carrier_low_pin_release);
  endproperty
  a_cl_rel: assert property (p_cl_rel) else $error("low release not one-hot");
  property p_ms_rel;
    $onehot0(modulator_pin_release);
  endproperty
  a_ms_rel: assert property (p_ms_rel) else $error("source release not one-hot");
  property p_ctl_zero;
    rd_ctl_r |-> hrdata[2:1] == 2'h0;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("unused bits read nonzero");
  property p_dis_status;
    rd_ctl_r && !hrdata[7] |-> hrdata[3] == hrdata[4];
  endproperty
  a_dis_status: assert property (p_dis_status) else $error("disabled mix not ground");
  property p_ctl_src;
    $changed(output_slew_limit) || $changed(modulated_output_oe_n) |-> wcnt_r != 3'h0;
  endproperty
  a_ctl_src: assert property (p_ctl_src) else $error("control output moved alone");
endmodule : cdm_modulator_monitor
bind cdm_modulator cdm_modulator_monitor u_mon (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .modulated_output, .modulated_output_oe_n, .output_slew_limit,
  .carrier_high_pin_release, .carrier_low_pin_release, .modulator_pin_release);

// [verif/cdm_peer.sv]
// cdm_peer: carrier and modulator source peripherals
// assumes: levels chosen by the bench, launched on clk_sys
`timescale 1ns/10ps
module cdm_peer (
  input wire logic clk_sys,
  input wire logic [7:0] car_lvl,
  input wire logic [9:0] mod_lvl,
  output logic [7:0] carrier_src_in,
  output logic [9:0] modulator_src_in,
  output logic modulator_pin_in
);
  always_ff @(posedge clk_sys) begin
    carrier_src_in <= car_lvl;
    modulator_src_in <= mod_lvl;
    modulator_pin_in <= mod_lvl[0];
  end
endmodule : cdm_peer

// [verif/cdm_modulator_test.sv]
// cdm_modulator_test: directed bench for the modulator block
// assumes: this module is the ahb-lite master, cdm_peer feeds sources
`timescale 1ns/10ps
module cdm_modulator_test
  import cdm_pkg::*;
;
  logic clk_sys = 1'h0, rst_n = 1'h0, sleep_mode = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = CDM_HSIZE_WORD;
  logic hreadyout, hresp, modulated_output, modulated_output_oe_n, output_slew_limit;
  logic modulator_pin_in;
  logic [7:0] car_lvl = 8'h0, carrier_src_in, carrier_high_pin_release, carrier_low_pin_release;
  logic [9:0] mod_lvl = 10'h0, modulator_src_in, modulator_pin_release;
  int fail_count = 0, checked = 0;
  cdm_peer peer (.clk_sys, .car_lvl, .mod_lvl, .carrier_src_in, .modulator_src_in,
    .modulator_pin_in);
  cdm_modulator dut (.clk_sys, .rst_n, .sleep_mode, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .carrier_src_in,
    .modulator_src_in, .modulator_pin_in, .modulated_output, .modulated_output_oe_n,
    .output_slew_limit, .carrier_high_pin_release, .carrier_low_pin_release,
    .modulator_pin_release);
  always #12.5 clk_sys = ~clk_sys;
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    if (n >= 40) begin
      chk(32'h0, 32'h1, "bus timeout");
      end_of_test;
    end
  endtask : wait_rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= CDM_HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy;
    rd_d = hrdata;
    if (w) repeat (4) @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'h0, 8'h0);
    chk(rd_d, exp, "read value");
    chk({hreadyout, hresp}, 2'h2, "bus response not ready okay");
  endtask : rd
  task automatic t_reset;
    rd(CDM_OFF_CTL, 32'h20);
    chk(modulated_output_oe_n, 1'h1, "pin enable at reset");
    rd(CDM_OFF_HIGH_CARRIER, 32'h0);
    bus(CDM_OFF_CTL, 1'h1, 8'h0E);
    rd(CDM_OFF_CTL, 32'h0);
    chk(output_slew_limit, 1'h0, "slew off");
  endtask : t_reset
  task automatic t_mix;
    car_lvl <= 8'hFF;
    bus(CDM_OFF_SRC, 1'h1, 8'h00);
    bus(CDM_OFF_HIGH_CARRIER, 1'h1, 8'h01);
    bus(CDM_OFF_LOW_CARRIER, 1'h1, 8'h02);
    bus(CDM_OFF_CTL, 1'h1, 8'h61);
    chk(modulated_output, 1'h0, "disabled output");
    rd(CDM_OFF_HIGH_CARRIER, 32'h1);
    car_lvl <= 8'h02;
    sleep_mode <= 1'h1;
    bus(CDM_OFF_CTL, 1'h1, 8'hC1);
    chk(modulated_output, 1'h1, "high carrier mix");
    chk(modulated_output_oe_n, 1'h0, "pin enable low");
    rd(CDM_OFF_CTL, 32'hC9);
    bus(CDM_OFF_CTL, 1'h1, 8'hD1);
    chk(modulated_output, 1'h0, "inverted mix");
    bus(CDM_OFF_CTL, 1'h1, 8'hD0);
    chk(modulated_output, 1'h1, "inverted low mix");
    bus(CDM_OFF_CTL, 1'h1, 8'h81);
    chk({modulated_output_oe_n, modulated_output}, 2'h2, "pin off");
    rd(CDM_OFF_CTL, 32'h89);
  endtask : t_mix
  task automatic t_release;
    bus(CDM_OFF_HIGH_CARRIER, 1'h1, 8'h81);
    bus(CDM_OFF_LOW_CARRIER, 1'h1, 8'h82);
    bus(CDM_OFF_SRC, 1'h1, 8'h82);
    chk(carrier_high_pin_release, 8'h02, "high release");
    chk(carrier_low_pin_release, 8'h04, "low release");
    chk(modulator_pin_release, 10'h001, "source release");
    rd(8'h10, 32'h0);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    chk(carrier_high_pin_release, 8'h0, "release after reset");
    rd(CDM_OFF_CTL, 32'h20);
    rd(CDM_OFF_SRC, 32'h0);
  endtask : t_release
  // external modulator pin with an inverted high carrier
  task automatic t_source;
    mod_lvl <= 10'h001;
    bus(CDM_OFF_SRC, 1'h1, 8'h01);
    bus(CDM_OFF_HIGH_CARRIER, 1'h1, 8'h41);
    bus(CDM_OFF_CTL, 1'h1, 8'hC0);
    chk({modulated_output_oe_n, modulated_output}, 2'h0, "inverted carrier high");
    car_lvl <= 8'h00;
    repeat (5) @(posedge clk_sys);
    chk({modulated_output_oe_n, modulated_output}, 2'h1, "pin source mix");
  endtask : t_source
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    t_reset;
    t_mix;
    t_release;
    t_source;
    end_of_test;
  end
endmodule : cdm_modulator_test
